// ---- rtl/csec_commit_arbiter.sv ----
`timescale 1ns/100ps

// Decides which of the two threads may commit in the next cycle.
module csec_commit_arbiter (
    input wire logic clk,
    input wire logic rst,
    input wire logic thread0_active,
    input wire logic thread1_active,
    output logic prio_thread_q
);

    typedef struct packed {
        logic prio_thread;
    } csec_arb_s;

    csec_arb_s st_q;
    csec_arb_s st_d;

    // Priority flips every cycle while both threads run; a lone active thread takes it, and with neither active it holds.
    always_comb begin
        st_d = st_q;
        if (thread0_active && thread1_active) begin
            st_d.prio_thread = ~st_q.prio_thread;
        end else if (thread0_active) begin
            st_d.prio_thread = 1'b0;
        end else if (thread1_active) begin
            st_d.prio_thread = 1'b1;
        end
    end

    // A single register bit means only one thread ever holds the grant.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '{prio_thread: csec_pkg::RESET_PRIO_THREAD};
        end else begin
            st_q <= st_d;
        end
    end

    assign prio_thread_q = st_q.prio_thread;

endmodule : csec_commit_arbiter

// ---- rtl/csec_event_qual.sv ----
`timescale 1ns/100ps

// Notes on behaviour
// - Count cycles issue stalls while the window register cache is being replaced.
// - Decode interlock counts all static interlocks, including sync and window, never dynamic ones.
// - Pulse when a predicted taken branch decodes as a non-branch.
// - Operand data wait: no commit, oldest entry is memory access with data unready.
// - Plain stores never add to operand data wait; atomics do.
// - Priority variants count the base stall only while this thread holds priority.
// - Non-cacheable operand wait counts operand waits from pending non-cache accesses.
// - Integer-load wait: no commit, oldest entry is an unfinished integer load.
// - L2-miss variants count operand and integer-load waits caused by L2 misses.
// - Count no-commit cycles with empty queue, and those also with full store port.
// - Execution-unit wait wins over branch completion wait in the same cycle.
// - Float wait: no commit, oldest entry is an unfinished floating-point instruction.
// - Qualified window-move and zero-commit count only when this thread lacks priority.
// - One thread commits per cycle; priority alternates while both threads run.
// - Priority wait counts ready-to-commit cycles without priority, never with nothing pending.
// - Commit histogram flags exactly one of zero to three commits per cycle, and none for more than three.
// - Write-port inhibit counts cycles below four commits for lack of write ports.
// - Separate instruction and data micro-TLB miss events; main TLB misses not here.
// - Separate instruction and data L1 miss events, one pulse per miss.
// - Miss latency sums exclusive wait causes, one per cycle, oldest non-prefetch only.
// - Each software prefetch lands in exactly one of forwarded, lost or L1 hit.
// - Thrash pulses when a read port re-requests the same line before release.
module csec_event_qual #(
    parameter int THREAD_ID = 0,
    parameter int WAIT_CAUSES = csec_pkg::WAIT_CAUSES,
    parameter int READ_PORTS = csec_pkg::READ_PORTS,
    parameter int LINE_ADDR_W = csec_pkg::LINE_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    // Issue and decode stage.
    input wire logic window_cache_replace_stall,
    input wire logic sync_stall,
    input wire logic other_static_stall,
    input wire logic dynamic_stall,
    input wire logic predicted_taken,
    input wire logic decoded_not_branch,
    // Thread activity, shared commit priority.
    input wire logic this_thread_active,
    input wire logic other_thread_active,
    // Commit stage, oldest queue entry of this thread.
    input wire logic [csec_pkg::COMMIT_CNT_W-1:0] commit_count,
    input wire logic commit_queue_empty,
    input wire logic store_port_full,
    input wire logic toq_valid,
    input wire logic toq_complete,
    input wire logic toq_is_mem,
    input wire logic toq_is_store,
    input wire logic toq_is_atomic,
    input wire logic toq_data_ready,
    input wire logic toq_noncache_pend,
    input wire logic toq_is_int_load,
    input wire logic toq_l2_miss,
    input wire logic toq_is_exec,
    input wire logic toq_is_float,
    input wire logic toq_is_branch,
    input wire logic toq_window_move,
    input wire logic write_ports_short,
    // TLB and L1 caches, index 0 instruction and index 1 data.
    input wire logic [csec_pkg::SIDES-1:0] micro_tlb_miss,
    input wire logic [csec_pkg::SIDES-1:0] l1_miss,
    input wire logic [csec_pkg::SIDES-1:0] oldest_is_prefetch,
    input wire logic [csec_pkg::SIDES-1:0][WAIT_CAUSES-1:0] miss_wait_cause,
    input wire logic [csec_pkg::SIDES-1:0] movein_req,
    input wire logic [csec_pkg::SIDES-1:0][$clog2(READ_PORTS)-1:0] movein_port,
    input wire logic [csec_pkg::SIDES-1:0][LINE_ADDR_W-1:0] movein_line,
    input wire logic [csec_pkg::SIDES-1:0][READ_PORTS-1:0] port_release,
    // Software prefetch outcome from the storage unit.
    input wire logic swpf_done,
    input wire logic swpf_l1_hit,
    input wire logic swpf_forwarded,
    // Count enables, one cycle after their cause.
    output logic commit_allow_q,
    output logic window_intlk_q,
    output logic decode_intlk_q,
    output logic phantom_branch_q,
    output logic [csec_pkg::STALL_COUNT-1:0] stall_q,
    output logic [csec_pkg::STALL_COUNT-1:0] stall_prio_q,
    output logic window_move_wait_q,
    output logic window_move_wait_noprio_q,
    output logic zero_commit_noprio_q,
    output logic priority_wait_q,
    output logic [csec_pkg::HIST_BUCKETS-1:0] commit_width_q,
    output logic write_port_inhibit_q,
    output logic [csec_pkg::SIDES-1:0] micro_tlb_miss_q,
    output logic [csec_pkg::SIDES-1:0] l1_miss_q,
    output logic [csec_pkg::SIDES-1:0][WAIT_CAUSES-1:0] miss_wait_q,
    output logic [csec_pkg::SIDES-1:0] miss_latency_total_q,
    output logic swpf_success_q,
    output logic swpf_lost_q,
    output logic swpf_l1_hit_q,
    output logic [csec_pkg::SIDES-1:0] line_thrash_q
);

    localparam int SD = csec_pkg::SIDES;
    localparam int PW = $clog2(READ_PORTS);

    typedef struct packed {
        logic commit_allow;
        logic window_intlk;
        logic decode_intlk;
        logic phantom_branch;
        logic [csec_pkg::STALL_COUNT-1:0] stall;
        logic [csec_pkg::STALL_COUNT-1:0] stall_prio;
        logic window_move_wait;
        logic window_move_wait_noprio;
        logic zero_commit_noprio;
        logic priority_wait;
        logic [csec_pkg::HIST_BUCKETS-1:0] commit_width;
        logic write_port_inhibit;
        logic [SD-1:0] micro_tlb_miss;
        logic [SD-1:0] l1_miss;
        logic [SD-1:0][WAIT_CAUSES-1:0] miss_wait;
        logic [SD-1:0] miss_latency_total;
        logic swpf_success;
        logic swpf_lost;
        logic swpf_l1_hit;
        logic [SD-1:0] line_thrash;
        logic [SD-1:0][READ_PORTS-1:0] port_busy;
        logic [SD-1:0][READ_PORTS-1:0][LINE_ADDR_W-1:0] port_line;
    } csec_qual_s;

    csec_qual_s st_q;
    csec_qual_s st_d;
    logic prio_thread_q;
    logic has_prio;

    // Keeps the lowest-numbered cause so that at most one wait bit rises per cycle.
    function automatic logic [WAIT_CAUSES-1:0] csec_first_cause(input logic [WAIT_CAUSES-1:0] req);
        logic [WAIT_CAUSES-1:0] pick;
        logic found;
        pick = '0;
        found = 1'b0;
        for (int i = 0; i < WAIT_CAUSES; i++) begin
            if (req[i] && !found) begin
                pick[i] = 1'b1;
                found = 1'b1;
            end
        end
        return pick;
    endfunction : csec_first_cause

    // True when a read port already holds a move-in for the requested line.
    function automatic logic csec_repeat_movein(
        input logic busy,
        input logic [LINE_ADDR_W-1:0] held_line,
        input logic [LINE_ADDR_W-1:0] req_line
    );
        return busy && (held_line == req_line);
    endfunction : csec_repeat_movein

    csec_commit_arbiter u_arbiter (
        .clk(clk),
        .rst(rst),
        .thread0_active(THREAD_ID == 0 ? this_thread_active : other_thread_active),
        .thread1_active(THREAD_ID == 0 ? other_thread_active : this_thread_active),
        .prio_thread_q(prio_thread_q)
    );

    // The grant computed last cycle is the priority in force in this cycle.
    assign has_prio = (prio_thread_q == THREAD_ID[0]);

    // All qualification is combinational on this cycle's inputs; outputs lag by one cycle.
    always_comb begin
        logic no_commit;
        logic oldest_wait;
        logic op_wait;
        logic ld_wait;
        logic exec_wait;
        logic [csec_pkg::STALL_COUNT-1:0] stall;
        logic [WAIT_CAUSES-1:0] cause;
        no_commit = 1'b0;
        oldest_wait = 1'b0;
        op_wait = 1'b0;
        ld_wait = 1'b0;
        exec_wait = 1'b0;
        stall = '0;
        cause = '0;
        st_d = st_q;

        st_d.commit_allow = has_prio && this_thread_active;

        // Decode-stage interlocks; dynamic stalls are deliberately not looked at.
        st_d.window_intlk = window_cache_replace_stall;
        st_d.decode_intlk = window_cache_replace_stall || sync_stall || other_static_stall;
        st_d.phantom_branch = predicted_taken && decoded_not_branch;

        no_commit = (commit_count == '0);
        oldest_wait = no_commit && toq_valid && !commit_queue_empty;

        // A plain store leaves the queue before its data lands, so only atomics wait.
        op_wait = oldest_wait && toq_is_mem && !toq_data_ready && (!toq_is_store || toq_is_atomic);
        ld_wait = oldest_wait && toq_is_int_load && !toq_complete;
        exec_wait = oldest_wait && toq_is_exec && !toq_complete;

        stall[csec_pkg::STALL_OPERAND_DATA_WAIT] = op_wait;
        stall[csec_pkg::STALL_OPERAND_WAIT_NONCACHE] = op_wait && toq_noncache_pend;
        stall[csec_pkg::STALL_INTEGER_LOAD_WAIT] = ld_wait;
        stall[csec_pkg::STALL_OPERAND_WAIT_L2_MISS] = op_wait && toq_l2_miss;
        stall[csec_pkg::STALL_INTEGER_LOAD_WAIT_L2_MISS] = ld_wait && toq_l2_miss;
        stall[csec_pkg::STALL_COMMIT_QUEUE_EMPTY] = no_commit && commit_queue_empty;
        stall[csec_pkg::STALL_COMMIT_QUEUE_EMPTY_STORE_FULL] =
            no_commit && commit_queue_empty && store_port_full;
        stall[csec_pkg::STALL_EXEC_UNIT_COMPLETION_WAIT] = exec_wait;
        stall[csec_pkg::STALL_BRANCH_COMPLETION_WAIT] =
            oldest_wait && toq_is_branch && !toq_complete && !exec_wait;
        stall[csec_pkg::STALL_FLOAT_COMPLETION_WAIT] = oldest_wait && toq_is_float && !toq_complete;
        st_d.stall = stall;

        // Priority-qualified copies, plus the two events kept for the thread without priority.
        st_d.stall_prio = has_prio ? stall : '0;
        st_d.window_move_wait = oldest_wait && toq_window_move;
        st_d.window_move_wait_noprio = oldest_wait && toq_window_move && !has_prio;
        st_d.zero_commit_noprio = no_commit && !has_prio;

        // Ready means an oldest entry that has completed; an empty queue never counts.
        st_d.priority_wait = toq_valid && !commit_queue_empty && toq_complete && !has_prio;

        // Four commits fall in no bucket; the zero bucket ignores priority.
        st_d.commit_width = '0;
        if (commit_count < csec_pkg::HIST_BUCKETS[csec_pkg::COMMIT_CNT_W-1:0]) begin
            st_d.commit_width[commit_count[1:0]] = 1'b1;
        end
        st_d.write_port_inhibit =
            write_ports_short && (commit_count < csec_pkg::COMMIT_MAX[csec_pkg::COMMIT_CNT_W-1:0]);

        st_d.micro_tlb_miss = micro_tlb_miss;
        st_d.l1_miss = l1_miss;

        // Per side, the oldest access alone is timed and nothing is timed while the oldest is a prefetch.
        for (int s = 0; s < SD; s++) begin
            cause = oldest_is_prefetch[s] ? '0 : csec_first_cause(miss_wait_cause[s]);
            st_d.miss_wait[s] = cause;
            st_d.miss_latency_total[s] = |cause;
        end

        // The hit check comes first so a prefetch can never land in two buckets.
        st_d.swpf_l1_hit = swpf_done && swpf_l1_hit;
        st_d.swpf_success = swpf_done && !swpf_l1_hit && swpf_forwarded;
        st_d.swpf_lost = swpf_done && !swpf_l1_hit && !swpf_forwarded;

        // Release is applied before a new request so a port can be freed and refilled at once.
        for (int s = 0; s < SD; s++) begin
            st_d.line_thrash[s] = 1'b0;
            st_d.port_busy[s] = st_q.port_busy[s] & ~port_release[s];
            if (movein_req[s]) begin
                st_d.line_thrash[s] = csec_repeat_movein(st_d.port_busy[s][movein_port[s]],
                    st_q.port_line[s][movein_port[s]], movein_line[s]);
                st_d.port_busy[s][movein_port[s]] = 1'b1;
                st_d.port_line[s][movein_port[s]] = movein_line[s];
            end
        end
    end

    // One register stage for the whole state, so every output leaves a flip-flop.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Output ports read straight from the registered state.
    assign commit_allow_q = st_q.commit_allow;
    assign window_intlk_q = st_q.window_intlk;
    assign decode_intlk_q = st_q.decode_intlk;
    assign phantom_branch_q = st_q.phantom_branch;
    assign stall_q = st_q.stall;
    assign stall_prio_q = st_q.stall_prio;
    assign window_move_wait_q = st_q.window_move_wait;
    assign window_move_wait_noprio_q = st_q.window_move_wait_noprio;
    assign zero_commit_noprio_q = st_q.zero_commit_noprio;
    assign priority_wait_q = st_q.priority_wait;
    assign commit_width_q = st_q.commit_width;
    assign write_port_inhibit_q = st_q.write_port_inhibit;
    assign micro_tlb_miss_q = st_q.micro_tlb_miss;
    assign l1_miss_q = st_q.l1_miss;
    assign miss_wait_q = st_q.miss_wait;
    assign miss_latency_total_q = st_q.miss_latency_total;
    assign swpf_success_q = st_q.swpf_success;
    assign swpf_lost_q = st_q.swpf_lost;
    assign swpf_l1_hit_q = st_q.swpf_l1_hit;
    assign line_thrash_q = st_q.line_thrash;

endmodule : csec_event_qual

// ---- rtl/csec_pkg.sv ----
package csec_pkg;

    // Positions of the commit-stage stall events within the stall vectors.
    localparam int STALL_OPERAND_DATA_WAIT = 0;
    localparam int STALL_OPERAND_WAIT_NONCACHE = 1;
    localparam int STALL_INTEGER_LOAD_WAIT = 2;
    localparam int STALL_OPERAND_WAIT_L2_MISS = 3;
    localparam int STALL_INTEGER_LOAD_WAIT_L2_MISS = 4;
    localparam int STALL_COMMIT_QUEUE_EMPTY_STORE_FULL = 5;
    localparam int STALL_COMMIT_QUEUE_EMPTY = 6;
    localparam int STALL_BRANCH_COMPLETION_WAIT = 7;
    localparam int STALL_EXEC_UNIT_COMPLETION_WAIT = 8;
    localparam int STALL_FLOAT_COMPLETION_WAIT = 9;
    localparam int STALL_COUNT = 10;

    // Commit width: at most four per cycle, histogram buckets zero to three.
    localparam int COMMIT_MAX = 4;
    localparam int COMMIT_CNT_W = 3;
    localparam int HIST_BUCKETS = 4;

    // Default shapes of the miss-latency causes and the move-in read ports.
    localparam int WAIT_CAUSES = 4;
    localparam int READ_PORTS = 4;
    localparam int LINE_ADDR_W = 34;

    // Side index of the two L1 caches in the miss and thrash vectors.
    localparam int SIDE_INSTR = 0;
    localparam int SIDE_DATA = 1;
    localparam int SIDES = 2;

    // Reset values.
    localparam logic RESET_EVENT = 1'b0;
    localparam logic RESET_PRIO_THREAD = 1'b0;

endpackage : csec_pkg

// ---- sim/csec_event_qual_checker.sv ----
`timescale 1ns/100ps

// Ties a subset of the count enables to their causes one cycle earlier.
module csec_event_qual_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic window_cache_replace_stall,
    input wire logic sync_stall,
    input wire logic other_static_stall,
    input wire logic predicted_taken,
    input wire logic decoded_not_branch,
    input wire logic this_thread_active,
    input wire logic other_thread_active,
    input wire logic [2:0] commit_count,
    input wire logic commit_queue_empty,
    input wire logic toq_valid,
    input wire logic toq_complete,
    input wire logic toq_is_exec,
    input wire logic toq_is_branch,
    input wire logic [1:0] micro_tlb_miss,
    input wire logic swpf_done,
    input wire logic commit_allow_q,
    input wire logic window_intlk_q,
    input wire logic decode_intlk_q,
    input wire logic phantom_branch_q,
    input wire logic [9:0] stall_q,
    input wire logic [3:0] commit_width_q,
    input wire logic [1:0] micro_tlb_miss_q,
    input wire logic swpf_success_q,
    input wire logic swpf_lost_q,
    input wire logic swpf_l1_hit_q
);
    // One clock domain, so clocking and reset are declared once.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence both_on;
        this_thread_active && other_thread_active;
    endsequence

    // Every enable lags its cause by exactly one cycle.
    window_intlk_a: assert property (1'b1 |=> window_intlk_q == $past(window_cache_replace_stall))
        else $error("window interlock enable wrong");
    decode_any_a: assert property (sync_stall || other_static_stall |=> decode_intlk_q)
        else $error("decode interlock enable missing");
    phantom_cause_a: assert property (phantom_branch_q |-> $past(predicted_taken) && $past(decoded_not_branch))
        else $error("phantom branch without cause");
    hist_bucket_a: assert property (commit_count < 3'h4 |=> commit_width_q == (4'h1 << $past(commit_count)))
        else $error("commit width bucket wrong");
    utlb_miss_a: assert property (1'b1 |=> micro_tlb_miss_q == $past(micro_tlb_miss))
        else $error("micro tlb miss enable wrong");
    swpf_one_a: assert property (swpf_done |=> $onehot({swpf_success_q, swpf_lost_q, swpf_l1_hit_q}))
        else $error("prefetch outcome not exactly one");
    prio_toggle_a: assert property (both_on ##1 both_on |=> commit_allow_q != $past(commit_allow_q))
        else $error("commit priority did not alternate");
    exec_first_a: assert property (commit_count == 3'h0 && toq_valid && !commit_queue_empty && toq_is_exec
        && toq_is_branch && !toq_complete |=> stall_q[8] && !stall_q[7])
        else $error("branch wait counted over exec wait");

    // Main scenarios reached.
    cover property (swpf_done ##1 swpf_l1_hit_q);
    cover property (phantom_branch_q);
    cover property (both_on ##1 both_on ##1 commit_allow_q);
endmodule : csec_event_qual_checker

bind csec_event_qual csec_event_qual_checker csec_event_qual_checker_i (.clk, .rst, .window_cache_replace_stall,
    .sync_stall, .other_static_stall, .predicted_taken, .decoded_not_branch, .this_thread_active,
    .other_thread_active, .commit_count, .commit_queue_empty, .toq_valid, .toq_complete, .toq_is_exec,
    .toq_is_branch, .micro_tlb_miss, .swpf_done, .commit_allow_q, .window_intlk_q, .decode_intlk_q,
    .phantom_branch_q, .stall_q, .commit_width_q, .micro_tlb_miss_q, .swpf_success_q, .swpf_lost_q, .swpf_l1_hit_q);

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps

module tb_top;
    logic clk, rst, window_cache_replace_stall, sync_stall, other_static_stall, dynamic_stall, predicted_taken;
    logic decoded_not_branch, this_thread_active, other_thread_active, commit_queue_empty, store_port_full;
    logic toq_valid, toq_complete, toq_is_mem, toq_is_store, toq_is_atomic, toq_data_ready, toq_noncache_pend;
    logic toq_is_int_load, toq_l2_miss, toq_is_exec, toq_is_float, toq_is_branch, toq_window_move;
    logic write_ports_short, swpf_done, swpf_l1_hit, swpf_forwarded;
    logic [2:0] commit_count;
    logic [1:0] micro_tlb_miss, l1_miss, oldest_is_prefetch, movein_req;
    logic [1:0][3:0] miss_wait_cause, port_release, miss_wait_q;
    logic [1:0][1:0] movein_port;
    logic [1:0][33:0] movein_line;
    logic commit_allow_q, window_intlk_q, decode_intlk_q, phantom_branch_q, window_move_wait_q, priority_wait_q;
    logic window_move_wait_noprio_q, zero_commit_noprio_q, write_port_inhibit_q;
    logic swpf_success_q, swpf_lost_q, swpf_l1_hit_q;
    logic [9:0] stall_q, stall_prio_q;
    logic [3:0] commit_width_q;
    logic [1:0] micro_tlb_miss_q, l1_miss_q, miss_latency_total_q, line_thrash_q;
    int err_total = 0;
    int tests_run = 0;

    csec_event_qual csec_event_qual_i (.clk, .rst, .window_cache_replace_stall, .sync_stall, .other_static_stall,
        .dynamic_stall, .predicted_taken, .decoded_not_branch, .this_thread_active, .other_thread_active,
        .commit_count, .commit_queue_empty, .store_port_full, .toq_valid, .toq_complete, .toq_is_mem,
        .toq_is_store, .toq_is_atomic, .toq_data_ready, .toq_noncache_pend, .toq_is_int_load, .toq_l2_miss,
        .toq_is_exec, .toq_is_float, .toq_is_branch, .toq_window_move, .write_ports_short, .micro_tlb_miss,
        .l1_miss, .oldest_is_prefetch, .miss_wait_cause, .movein_req, .movein_port, .movein_line,
        .port_release, .swpf_done, .swpf_l1_hit, .swpf_forwarded, .commit_allow_q, .window_intlk_q,
        .decode_intlk_q, .phantom_branch_q, .stall_q, .stall_prio_q, .window_move_wait_q,
        .window_move_wait_noprio_q, .zero_commit_noprio_q, .priority_wait_q, .commit_width_q,
        .write_port_inhibit_q, .micro_tlb_miss_q, .l1_miss_q, .miss_wait_q, .miss_latency_total_q,
        .swpf_success_q, .swpf_lost_q, .swpf_l1_hit_q, .line_thrash_q);

    // Free-running 100 MHz core clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Inputs change 1 ns after the edge, so the design never races the bench.
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic idle;
        {window_cache_replace_stall, sync_stall, other_static_stall, dynamic_stall, predicted_taken,
            decoded_not_branch, this_thread_active, other_thread_active, commit_queue_empty, store_port_full,
            toq_valid, toq_complete, toq_is_mem, toq_is_store, toq_is_atomic, toq_data_ready, toq_noncache_pend,
            toq_is_int_load, toq_l2_miss, toq_is_exec, toq_is_float, toq_is_branch, toq_window_move,
            write_ports_short, swpf_done, swpf_l1_hit, swpf_forwarded, commit_count, micro_tlb_miss, l1_miss,
            oldest_is_prefetch, movein_req, miss_wait_cause, port_release, movein_port, movein_line} = '0;
    endtask : idle

    task automatic t_decode;
        window_cache_replace_stall = 1'b1;
        tick();
        chk("window_intlk_q", 1, window_intlk_q);
        chk("decode_intlk_q", 1, decode_intlk_q);
        window_cache_replace_stall = 1'b0;
        dynamic_stall = 1'b1;
        predicted_taken = 1'b1;
        tick();
        chk("decode_intlk_q", 0, decode_intlk_q);
        chk("phantom_branch_q", 0, phantom_branch_q);
        sync_stall = 1'b1;
        decoded_not_branch = 1'b1;
        tick();
        chk("decode_intlk_q", 1, decode_intlk_q);
        chk("phantom_branch_q", 1, phantom_branch_q);
        {sync_stall, other_static_stall} = 2'h1;
        tick();
        chk("decode_intlk_q other", 1, decode_intlk_q);
        idle();
    endtask : t_decode

    // Lone active thread takes priority, then the other thread takes it away.
    task automatic t_opwait;
        this_thread_active = 1'b1;
        {toq_valid, toq_is_mem, toq_is_store, toq_noncache_pend, toq_l2_miss} = 5'h1F;
        tick();
        tick();
        chk("stall_q store", 0, stall_q);
        toq_is_atomic = 1'b1;
        tick();
        chk("stall_q", 10'h00B, stall_q);
        chk("stall_prio_q", 10'h00B, stall_prio_q);
        this_thread_active = 1'b0;
        other_thread_active = 1'b1;
        tick();
        tick();
        chk("stall_q", 10'h00B, stall_q);
        chk("stall_prio_q", 0, stall_prio_q);
        toq_data_ready = 1'b1;
        tick();
        chk("stall_q ready", 0, stall_q);
        idle();
        {toq_valid, toq_is_int_load, toq_l2_miss, toq_is_float} = 4'hF;
        tick();
        chk("stall_q load", 10'h214, stall_q);
        idle();
        {commit_queue_empty, store_port_full} = 2'h3;
        tick();
        chk("stall_q empty", 10'h060, stall_q);
        idle();
    endtask : t_opwait

    task automatic t_exec;
        {toq_valid, toq_is_exec, toq_is_branch} = 3'h7;
        tick();
        chk("stall_q exec", 10'h100, stall_q);
        toq_is_exec = 1'b0;
        tick();
        chk("stall_q branch", 10'h080, stall_q);
        idle();
    endtask : t_exec

    // Ready thread sharing the core waits every other cycle.
    task automatic t_prio;
        logic prev;
        {this_thread_active, other_thread_active, toq_valid, toq_complete, toq_window_move} = 5'h1F;
        tick();
        prev = commit_allow_q;
        repeat (4) begin
            tick();
            chk("commit_allow_q", !prev, commit_allow_q);
            chk("priority_wait_q", !commit_allow_q, priority_wait_q);
            chk("zero_commit_noprio_q", !commit_allow_q, zero_commit_noprio_q);
            chk("window_move_wait_q", 1, window_move_wait_q);
            chk("window_move_wait_noprio_q", !commit_allow_q, window_move_wait_noprio_q);
            prev = commit_allow_q;
        end
        commit_queue_empty = 1'b1;
        repeat (2) begin
            tick();
            chk("priority_wait_q empty", 0, priority_wait_q);
            chk("window_move_wait_q empty", 0, window_move_wait_q);
        end
        idle();
    endtask : t_prio

    task automatic t_hist;
        write_ports_short = 1'b1;
        for (int n = 0; n < 5; n++) begin
            commit_count = 3'(n);
            tick();
            chk("commit_width_q", (n < 4) ? (1 << n) : 0, commit_width_q);
            chk("write_port_inhibit_q", n < 4, write_port_inhibit_q);
        end
        idle();
    endtask : t_hist

    task automatic t_miss;
        micro_tlb_miss = 2'h2;
        l1_miss = 2'h1;
        miss_wait_cause = 8'h68;
        oldest_is_prefetch = 2'h1;
        tick();
        chk("micro_tlb_miss_q", 2'h2, micro_tlb_miss_q);
        chk("l1_miss_q", 2'h1, l1_miss_q);
        chk("miss_wait_q", 8'h20, miss_wait_q);
        chk("miss_latency_total_q", 2'h2, miss_latency_total_q);
        idle();
    endtask : t_miss

    // Hit beats forwarded, and neither means the prefetch was lost.
    task automatic t_swpf;
        logic [2:0] exp;
        swpf_done = 1'b1;
        for (int k = 0; k < 4; k++) begin
            {swpf_l1_hit, swpf_forwarded} = 2'(k);
            exp = k[1] ? 3'h1 : (k[0] ? 3'h4 : 3'h2);
            tick();
            chk("swpf outcome", exp, {swpf_success_q, swpf_lost_q, swpf_l1_hit_q});
        end
        idle();
        tick();
        chk("swpf idle", 0, {swpf_success_q, swpf_lost_q, swpf_l1_hit_q});
    endtask : t_swpf

    task automatic t_thrash;
        movein_req = 2'h2;
        movein_port = 4'h8;
        movein_line = {34'h123, 34'h0};
        tick();
        chk("line_thrash_q first", 0, line_thrash_q);
        tick();
        chk("line_thrash_q again", 2'h2, line_thrash_q);
        port_release = 8'h40;
        tick();
        chk("line_thrash_q release", 0, line_thrash_q);
        idle();
    endtask : t_thrash

    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Reset for ten cycles, then one scenario after another.
    initial begin
        idle();
        rst = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_decode();
        t_opwait();
        t_exec();
        t_prio();
        t_hist();
        t_miss();
        t_swpf();
        t_thrash();
        report_and_stop();
    end

    // The run needs about 45 cycles; this limit only catches a hang.
    initial begin
        #20000;
        err_total++;
        report_and_stop();
    end
endmodule : tb_top
